// file: design/gtc_deadtime.v
// complementary pair generator with dead-time insertion
`include "gtc_defs.vh"
module gtc_deadtime (
    input wire sys_clk,
    input wire rst,
    input wire ref_in,
    input wire [7:0] dead_cycles,
    output reg out_p,
    output reg out_n
);
    reg ref_d_r;
    reg [7:0] gap_r;
    always @(posedge sys_clk) begin
        if (rst) begin
            ref_d_r <= 1'b0;
            gap_r <= 8'h00;
            out_p <= 1'b0;
            out_n <= 1'b0;
        end else begin
            ref_d_r <= ref_in;
            if (ref_in != ref_d_r) begin
                // both legs off for the whole gap
                gap_r <= dead_cycles;
                out_p <= 1'b0;
                out_n <= 1'b0;
            end else if (gap_r != 8'h00) begin
                gap_r <= gap_r - `GTC_ONE8;
                out_p <= 1'b0;
                out_n <= 1'b0;
            end else begin
                out_p <= ref_d_r;
                out_n <= ~ref_d_r;
            end
        end
    end
endmodule

// file: design/gtc_defs.vh
// register map, field positions and constants of the dual-channel timer
`ifndef GTC_DEFS_VH
`define GTC_DEFS_VH
`define GTC_ADDR_W 5
`define GTC_A_CTRL 5'h00
`define GTC_A_SMODE 5'h01
`define GTC_A_IEN 5'h02
`define GTC_A_STAT 5'h03
`define GTC_A_EVGEN 5'h04
`define GTC_A_CNT 5'h05
`define GTC_A_PSC 5'h06
`define GTC_A_ARR 5'h07
`define GTC_A_RCR 5'h08
`define GTC_A_CH1 5'h09
`define GTC_A_CH2 5'h0a
`define GTC_A_CHCFG 5'h0b
`define GTC_A_BDTR 5'h0c
// control bits
`define GTC_CTRL_EN 0
`define GTC_CTRL_OPM 1
`define GTC_CTRL_CMS 2
`define GTC_CTRL_URS 3
// slave mode field
`define GTC_SM_LO 0
`define GTC_SM_HI 2
`define GTC_TRG_POL 4
`define GTC_SM_OFF 3'h0
`define GTC_SM_RESET 3'h1
`define GTC_SM_GATE 3'h2
`define GTC_SM_START 3'h3
`define GTC_SM_EXTCLK 3'h4
`define GTC_SM_STOP 3'h5
// status bits
`define GTC_ST_UIF 0
`define GTC_ST_C1IF 1
`define GTC_ST_C2IF 2
`define GTC_ST_TIF 3
`define GTC_ST_BIF 4
`define GTC_ST_W 5
// event generation bits
`define GTC_EG_UG 0
`define GTC_EG_TG 3
// channel config per channel, 8 bits each
`define GTC_CC_CAP 0
`define GTC_CC_MODE_LO 1
`define GTC_CC_MODE_HI 3
`define GTC_CC_POL 4
`define GTC_CC_CLR 5
`define GTC_MODE_FROZEN 3'h0
`define GTC_MODE_ACT 3'h1
`define GTC_MODE_INACT 3'h2
`define GTC_MODE_TOGGLE 3'h3
`define GTC_MODE_PWM1 3'h6
`define GTC_MODE_PWM2 3'h7
// break and dead time
`define GTC_BD_DT_LO 0
`define GTC_BD_DT_HI 7
`define GTC_BD_BKE 8
`define GTC_BD_BKP 9
`define GTC_BD_MOE 10
`define GTC_BD_OIS1 11
`define GTC_BD_OIS1N 12
`define GTC_BD_OIS2 13
`define GTC_BD_OSSI 14
`define GTC_RST16 16'h0000
`define GTC_ARR_RST 16'hffff
`define GTC_ONE16 16'h0001
`define GTC_ONE8 8'h01
`endif

// file: design/gtc_sync3.v
// three-stage synchroniser, change accepted when stages two and three agree
module gtc_sync3 (
    input wire sys_clk,
    input wire rst,
    input wire din,
    output reg dout
);
    reg s1_r;
    reg s2_r;
    reg s3_r;
    always @(posedge sys_clk) begin
        if (rst) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            dout <= 1'b0;
        end else begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                dout <= s3_r;
            end
        end
    end
endmodule

// file: design/gtc_timer.v
// general purpose 16-bit timer with two capture/compare channels
// Operation
// - 16-bit up or up/down counter reloads automatically from auto-reload value each period.
// - 16-bit prescaler divides by 1 to 65536, changeable while running.
// - two independent channels, each input capture or output compare.
// - each channel makes edge-aligned or center-aligned PWM.
// - one-pulse mode emits one pulse then stops the counter.
// - complementary pair with programmable dead time, both inactive in gap.
// - repetition counter delays update events and register transfer.
// - break input forces outputs to reset or programmed idle state.
// - update flag on overflow, underflow, software or trigger reinit.
// - trigger flag when trigger starts, stops, resets or clocks counter.
// - capture latches counter into channel register and sets capture flag.
// - compare flag when counter matches channel compare value.
// - break flag when break input asserts.
// - slave-mode logic lets external signals control and chain timers.
// - trigger input used as external clock or cycle-by-cycle current limit.
`include "gtc_defs.vh"
module gtc_timer (
    input wire sys_clk,
    input wire rst,
    input wire [`GTC_ADDR_W-1:0] addr,
    input wire [31:0] wdata,
    input wire wr,
    input wire rd,
    output reg [31:0] rdata,
    input wire trg_in,
    input wire brk_in,
    input wire cap1_in,
    input wire cap2_in,
    output reg ch1_out,
    output reg ch1n_out,
    output reg ch2_out,
    output reg trg_out,
    output reg evt_req
);
    reg [3:0] ctrl_r;
    reg [4:0] smode_r;
    reg [4:0] ien_r;
    reg [4:0] stat_r;
    reg [15:0] cnt_r;
    reg [15:0] psc_r;
    reg [15:0] psc_act_r;
    reg [15:0] pcnt_r;
    reg [15:0] arr_r;
    reg [15:0] arr_act_r;
    reg [7:0] rcr_r;
    reg [7:0] rep_r;
    reg [15:0] ccr1_r;
    reg [15:0] ccr2_r;
    reg [15:0] ccr1_act_r;
    reg [15:0] ccr2_act_r;
    reg [15:0] chcfg_r;
    reg [14:0] bdtr_r;
    reg dir_down_r;
    reg oc1_r;
    reg oc2_r;
    reg trg_d_r;
    reg brk_d_r;
    reg cap1_d_r;
    reg cap2_d_r;
    wire trg_s;
    wire brk_s;
    wire cap1_s;
    wire cap2_s;
    wire p1;
    wire n1;

    gtc_sync3 u_sy_trg (.sys_clk(sys_clk), .rst(rst), .din(trg_in), .dout(trg_s));
    gtc_sync3 u_sy_brk (.sys_clk(sys_clk), .rst(rst), .din(brk_in), .dout(brk_s));
    gtc_sync3 u_sy_c1 (.sys_clk(sys_clk), .rst(rst), .din(cap1_in), .dout(cap1_s));
    gtc_sync3 u_sy_c2 (.sys_clk(sys_clk), .rst(rst), .din(cap2_in), .dout(cap2_s));
    gtc_deadtime u_dt (
        .sys_clk(sys_clk),
        .rst(rst),
        .ref_in(oc1_r),
        .dead_cycles(bdtr_r[`GTC_BD_DT_HI:`GTC_BD_DT_LO]),
        .out_p(p1),
        .out_n(n1)
    );

    wire [2:0] sm = smode_r[`GTC_SM_HI:`GTC_SM_LO];
    wire trg_lvl = trg_s ^ smode_r[`GTC_TRG_POL];
    wire trg_edge = trg_lvl & ~trg_d_r;
    wire brk_lvl = bdtr_r[`GTC_BD_BKE] & (brk_s ^ bdtr_r[`GTC_BD_BKP]);
    wire wr_cnt = wr && addr == `GTC_A_CNT;
    wire sw_ug = wr && addr == `GTC_A_EVGEN && wdata[`GTC_EG_UG];
    wire sw_tg = wr && addr == `GTC_A_EVGEN && wdata[`GTC_EG_TG];
    wire center = ctrl_r[`GTC_CTRL_CMS];
    wire running = ctrl_r[`GTC_CTRL_EN] && !(sm == `GTC_SM_GATE && !trg_lvl);
    // counter tick: prescaled sys_clk, or trigger edges in external clock mode
    wire pre_tick = (sm == `GTC_SM_EXTCLK) ? trg_edge : (pcnt_r == psc_act_r);
    wire tick = running && pre_tick;
    wire at_top = cnt_r == arr_act_r;
    wire ovf = tick && !center && at_top;
    wire c_top = tick && center && !dir_down_r && at_top;
    wire c_bot = tick && center && dir_down_r && cnt_r == `GTC_ONE16;
    wire wrap = ovf || c_top || c_bot;
    wire trg_reset = (sm == `GTC_SM_RESET) && trg_edge;
    wire trg_start = (sm == `GTC_SM_START) && trg_edge;
    wire trg_stop = (sm == `GTC_SM_STOP) && trg_edge;
    wire trg_evt = ((sm != `GTC_SM_OFF) && trg_edge) || sw_tg;
    wire rep_done = rep_r == 8'h00;
    wire upd = (wrap && rep_done) || sw_ug || trg_reset;
    wire cap1_ev = chcfg_r[`GTC_CC_CAP] && (cap1_s ^ chcfg_r[`GTC_CC_POL]) && !cap1_d_r;
    wire cap2_ev = chcfg_r[8+`GTC_CC_CAP] && (cap2_s ^ chcfg_r[8+`GTC_CC_POL]) && !cap2_d_r;
    wire cmp1_ev = !chcfg_r[`GTC_CC_CAP] && tick && cnt_r == ccr1_act_r;
    wire cmp2_ev = !chcfg_r[8+`GTC_CC_CAP] && tick && cnt_r == ccr2_act_r;
    wire [4:0] hw_set = {brk_lvl & ~brk_d_r, trg_evt, cap2_ev | cmp2_ev,
                         cap1_ev | cmp1_ev, upd};

    // output compare reference for one channel
    function oc_next;
        input [2:0] mode;
        input cur;
        input [15:0] cnt;
        input [15:0] ccr;
        input hit;
        begin
            case (mode)
                `GTC_MODE_ACT: oc_next = hit ? 1'b1 : cur;
                `GTC_MODE_INACT: oc_next = hit ? 1'b0 : cur;
                `GTC_MODE_TOGGLE: oc_next = hit ? ~cur : cur;
                `GTC_MODE_PWM1: oc_next = cnt < ccr;
                `GTC_MODE_PWM2: oc_next = !(cnt < ccr);
                default: oc_next = cur;
            endcase
        end
    endfunction

    always @(posedge sys_clk) begin
        if (rst) begin
            ctrl_r <= 4'h0;
            smode_r <= 5'h00;
            ien_r <= 5'h00;
            stat_r <= 5'h00;
            cnt_r <= `GTC_RST16;
            psc_r <= `GTC_RST16;
            psc_act_r <= `GTC_RST16;
            pcnt_r <= `GTC_RST16;
            arr_r <= `GTC_ARR_RST;
            arr_act_r <= `GTC_ARR_RST;
            rcr_r <= 8'h00;
            rep_r <= 8'h00;
            ccr1_r <= `GTC_RST16;
            ccr2_r <= `GTC_RST16;
            ccr1_act_r <= `GTC_RST16;
            ccr2_act_r <= `GTC_RST16;
            chcfg_r <= 16'h0000;
            bdtr_r <= 15'h0000;
            dir_down_r <= 1'b0;
            oc1_r <= 1'b0;
            oc2_r <= 1'b0;
            trg_d_r <= 1'b0;
            brk_d_r <= 1'b0;
            cap1_d_r <= 1'b0;
            cap2_d_r <= 1'b0;
        end else begin
            trg_d_r <= trg_lvl;
            brk_d_r <= brk_lvl;
            cap1_d_r <= cap1_s ^ chcfg_r[`GTC_CC_POL];
            cap2_d_r <= cap2_s ^ chcfg_r[8+`GTC_CC_POL];
            if (wr) begin
                case (addr)
                    `GTC_A_CTRL: ctrl_r <= wdata[3:0];
                    `GTC_A_SMODE: smode_r <= wdata[4:0];
                    `GTC_A_IEN: ien_r <= wdata[4:0];
                    `GTC_A_PSC: psc_r <= wdata[15:0];
                    `GTC_A_ARR: arr_r <= wdata[15:0];
                    `GTC_A_RCR: rcr_r <= wdata[7:0];
                    `GTC_A_CH1: ccr1_r <= wdata[15:0];
                    `GTC_A_CH2: ccr2_r <= wdata[15:0];
                    `GTC_A_CHCFG: chcfg_r <= wdata[15:0];
                    `GTC_A_BDTR: bdtr_r <= wdata[14:0];
                    default: ;
                endcase
            end
            // start/stop by trigger overrides software enable write
            if (trg_start) begin
                ctrl_r[`GTC_CTRL_EN] <= 1'b1;
            end else if (trg_stop || (upd && ctrl_r[`GTC_CTRL_OPM] && wrap)) begin
                ctrl_r[`GTC_CTRL_EN] <= 1'b0;
            end
            // write-one-to-clear; hardware set wins over clear
            if (wr && addr == `GTC_A_STAT) begin
                stat_r <= (stat_r & ~wdata[4:0]) | hw_set;
            end else begin
                stat_r <= stat_r | hw_set;
            end
            // prescaler: new ratio takes effect at the next update
            if (upd || pre_tick) begin
                pcnt_r <= `GTC_RST16;
            end else if (running) begin
                pcnt_r <= pcnt_r + `GTC_ONE16;
            end
            if (upd) begin
                psc_act_r <= psc_r;
                arr_act_r <= arr_r;
                ccr1_act_r <= ccr1_r;
                ccr2_act_r <= ccr2_r;
            end
            if (wrap) begin
                rep_r <= rep_done ? rcr_r : rep_r - `GTC_ONE8;
            end else if (sw_ug || trg_reset) begin
                rep_r <= rcr_r;
            end
            if (sw_ug || trg_reset) begin
                cnt_r <= `GTC_RST16;
                dir_down_r <= 1'b0;
            end else if (wr_cnt) begin
                cnt_r <= wdata[15:0];
            end else if (ovf) begin
                cnt_r <= `GTC_RST16;
            end else if (c_top) begin
                dir_down_r <= 1'b1;
                cnt_r <= cnt_r - `GTC_ONE16;
            end else if (c_bot) begin
                dir_down_r <= 1'b0;
                cnt_r <= `GTC_RST16;
            end else if (tick) begin
                cnt_r <= dir_down_r ? cnt_r - `GTC_ONE16 : cnt_r + `GTC_ONE16;
            end
            if (cap1_ev) begin
                ccr1_r <= cnt_r;
                ccr1_act_r <= cnt_r;
            end
            if (cap2_ev) begin
                ccr2_r <= cnt_r;
                ccr2_act_r <= cnt_r;
            end
            // current-limit: trigger clears the reference while its level stays active
            if (chcfg_r[`GTC_CC_CLR] && trg_lvl && sm == `GTC_SM_OFF) begin
                oc1_r <= 1'b0;
            end else if (!chcfg_r[`GTC_CC_CAP]) begin
                oc1_r <= oc_next(chcfg_r[`GTC_CC_MODE_HI:`GTC_CC_MODE_LO], oc1_r,
                                 cnt_r, ccr1_act_r, cmp1_ev);
            end
            if (chcfg_r[8+`GTC_CC_CLR] && trg_lvl && sm == `GTC_SM_OFF) begin
                oc2_r <= 1'b0;
            end else if (!chcfg_r[8+`GTC_CC_CAP]) begin
                oc2_r <= oc_next(chcfg_r[8+`GTC_CC_MODE_HI:8+`GTC_CC_MODE_LO], oc2_r,
                                 cnt_r, ccr2_act_r, cmp2_ev);
            end
            if (brk_lvl) begin
                bdtr_r[`GTC_BD_MOE] <= 1'b0;
            end
        end
    end

    // output stage: break or disabled main enable forces idle levels
    always @(posedge sys_clk) begin
        if (rst) begin
            ch1_out <= 1'b0;
            ch1n_out <= 1'b0;
            ch2_out <= 1'b0;
            trg_out <= 1'b0;
            evt_req <= 1'b0;
            rdata <= 32'h00000000;
        end else begin
            if (brk_lvl || !bdtr_r[`GTC_BD_MOE]) begin
                ch1_out <= bdtr_r[`GTC_BD_OSSI] & bdtr_r[`GTC_BD_OIS1];
                ch1n_out <= bdtr_r[`GTC_BD_OSSI] & bdtr_r[`GTC_BD_OIS1N];
                ch2_out <= bdtr_r[`GTC_BD_OSSI] & bdtr_r[`GTC_BD_OIS2];
            end else begin
                ch1_out <= p1 ^ chcfg_r[`GTC_CC_POL];
                ch1n_out <= n1 ^ chcfg_r[`GTC_CC_POL];
                ch2_out <= oc2_r ^ chcfg_r[8+`GTC_CC_POL];
            end
            // chaining output to other timers
            trg_out <= upd;
            evt_req <= |(stat_r & ien_r);
            rdata <= 32'h00000000;
            if (rd) begin
                case (addr)
                    `GTC_A_CTRL: rdata <= {28'h0, ctrl_r};
                    `GTC_A_SMODE: rdata <= {27'h0, smode_r};
                    `GTC_A_IEN: rdata <= {27'h0, ien_r};
                    `GTC_A_STAT: rdata <= {27'h0, stat_r};
                    `GTC_A_CNT: rdata <= {16'h0, cnt_r};
                    `GTC_A_PSC: rdata <= {16'h0, psc_r};
                    `GTC_A_ARR: rdata <= {16'h0, arr_r};
                    `GTC_A_RCR: rdata <= {24'h0, rcr_r};
                    `GTC_A_CH1: rdata <= {16'h0, ccr1_r};
                    `GTC_A_CH2: rdata <= {16'h0, ccr2_r};
                    `GTC_A_CHCFG: rdata <= {16'h0, chcfg_r};
                    `GTC_A_BDTR: rdata <= {17'h0, bdtr_r};
                    default: rdata <= 32'h00000000;
                endcase
            end
        end
    end
endmodule

// file: verification/gtc_pins.sv
// pin-side model driving trigger, break and capture inputs
module gtc_pins (
    input wire logic sys_clk,
    output logic trg_in,
    output logic brk_in,
    output logic cap1_in,
    output logic cap2_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] pin_r = 4'h0;
    assign {cap2_in, cap1_in, brk_in, trg_in} = pin_r;
    // held high and low long enough for the three-stage synchroniser to agree
    task automatic pulse(input int idx, input int hold);
        @(posedge sys_clk);
        pin_r[idx] <= 1'b1;
        repeat (hold) @(posedge sys_clk);
        pin_r[idx] <= 1'b0;
        repeat (hold) @(posedge sys_clk);
    endtask
endmodule

// file: verification/gtc_timer_assertions.sv
// port-level checker of the timer outputs
`include "gtc_defs.vh"
module gtc_timer_assertions (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [`GTC_ADDR_W-1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic brk_in,
    input wire logic cap1_in,
    input wire logic ch1_out,
    input wire logic ch1n_out,
    input wire logic ch2_out,
    input wire logic trg_out,
    input wire logic evt_req
);
    logic [4:0] ien_r;
    logic [15:0] bd_r;
    logic cap1m_r;
    logic moe_ever_r;
    logic [8:0] low_r;
    // shadow of the configuration, taken from bus writes
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ien_r <= 5'h00;
            bd_r <= 16'h0000;
            cap1m_r <= 1'b0;
            moe_ever_r <= 1'b0;
        end else if (wr) begin
            if (addr == `GTC_A_IEN) ien_r <= wdata[4:0];
            if (addr == `GTC_A_BDTR) bd_r <= wdata[15:0];
            if (addr == `GTC_A_BDTR && wdata[`GTC_BD_MOE]) moe_ever_r <= 1'b1;
            if (addr == `GTC_A_CHCFG) cap1m_r <= wdata[`GTC_CC_CAP] & ~wdata[`GTC_CC_POL];
        end
    end
    // saturating run length of cycles with both pair outputs low
    always_ff @(posedge sys_clk) begin
        if (rst || ch1_out || ch1n_out) low_r <= 9'h000;
        else if (low_r != 9'h1ff) low_r <= low_r + 9'h001;
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    sequence brk_edge;
        $rose(brk_in ^ bd_r[`GTC_BD_BKP]) && bd_r[`GTC_BD_BKE];
    endsequence
    sequence idle_seen;
        ch1_out == (bd_r[`GTC_BD_OSSI] & bd_r[`GTC_BD_OIS1]) &&
            ch1n_out == (bd_r[`GTC_BD_OSSI] & bd_r[`GTC_BD_OIS1N]) &&
            ch2_out == (bd_r[`GTC_BD_OSSI] & bd_r[`GTC_BD_OIS2]);
    endsequence
    pair_excl_a: assert property (!(ch1_out && ch1n_out))
        else $error("pair outputs both high");
    dead_gap_a: assert property ($rose(ch1_out) |-> low_r > {1'b0, bd_r[7:0]})
        else $error("dead time too short");
    brk_idle_a: assert property (brk_edge |-> ##[1:12] idle_seen)
        else $error("break did not force idle");
    brk_flag_a: assert property (brk_edge ##0 ien_r[4] |-> ##[1:12] evt_req)
        else $error("break request missing");
    cap_flag_a: assert property (cap1m_r && ien_r[1] && $rose(cap1_in) |-> ##[1:12] evt_req)
        else $error("capture request missing");
    upd_pulse_a: assert property (wr && addr == `GTC_A_EVGEN && wdata[`GTC_EG_UG]
        |-> ##[1:4] trg_out)
        else $error("software update gave no pulse");
    idle_before_a: assert property (!moe_ever_r && !bd_r[`GTC_BD_OSSI]
        |-> !ch1_out && !ch1n_out && !ch2_out)
        else $error("output active without enable");
    evt_cause_a: assert property (evt_req |->
        (ien_r != 5'h00 || $past(ien_r) != 5'h00 || $past(ien_r, 2) != 5'h00))
        else $error("request with no source enabled");
endmodule
bind gtc_timer gtc_timer_assertions u_chk (.sys_clk(sys_clk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .brk_in(brk_in), .cap1_in(cap1_in), .ch1_out(ch1_out),
    .ch1n_out(ch1n_out), .ch2_out(ch2_out), .trg_out(trg_out), .evt_req(evt_req));

// file: verification/gtc_timer_tb.sv
// self-checking bench for the dual-channel timer
`include "gtc_defs.vh"
module gtc_timer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [`GTC_ADDR_W-1:0] addr = 5'h00;
    logic [31:0] wdata = 32'h00000000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    wire [31:0] rdata;
    wire trg_in, brk_in, cap1_in, cap2_in, ch1_out, ch1n_out, ch2_out, trg_out, evt_req;
    int miscompares = 0;
    int checks_done = 0;
    int cycles = 0;
    int n, hi1, hi2;
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    gtc_timer u_dut (.sys_clk(sys_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .trg_in(trg_in), .brk_in(brk_in), .cap1_in(cap1_in),
        .cap2_in(cap2_in), .ch1_out(ch1_out), .ch1n_out(ch1n_out), .ch2_out(ch2_out),
        .trg_out(trg_out), .evt_req(evt_req));
    gtc_pins u_pins (.sys_clk(sys_clk), .trg_in(trg_in), .brk_in(brk_in),
        .cap1_in(cap1_in), .cap2_in(cap2_in));
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr_reg(input logic [`GTC_ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input string name, input logic [`GTC_ADDR_W-1:0] a,
        input logic [31:0] exp, input logic [31:0] mask);
        @(posedge sys_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1 chk(name, exp & mask, rdata & mask);
    endtask
    // first interval after a change is skipped, it may mix old and new settings
    task automatic gap(output int len);
        int k;
        len = 0;
        for (k = 0; k < 3 && len < 3000; len++) begin
            @(negedge sys_clk);
            if (trg_out === 1'b1) begin
                k++;
                if (k == 2) len = -1;
            end
        end
    endtask
    // any window of one whole period holds the same high time
    task automatic high_count(input int len);
        hi1 = 0;
        hi2 = 0;
        repeat (len) begin
            @(negedge sys_clk);
            hi1 += (ch1_out === 1'b1);
            hi2 += (ch1n_out === 1'b1);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 60000) begin
            miscompares++;
            $display("mismatch timeout expected finish seen hang");
            end_of_test();
        end
    end
    initial begin
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        rd_chk("arr", `GTC_A_ARR, 32'h0000ffff, 32'hffffffff);
        rd_chk("cnt", `GTC_A_CNT, 32'h00000000, 32'hffffffff);
        rd_chk("psc", `GTC_A_PSC, 32'h00000000, 32'hffffffff);
        rd_chk("unmapped", 5'h1f, 32'h00000000, 32'hffffffff);
        $display("test reset done");
        wr_reg(`GTC_A_ARR, 32'h00000009);
        wr_reg(`GTC_A_EVGEN, 32'h00000001);
        wr_reg(`GTC_A_CTRL, 32'h00000001);
        gap(n);
        chk("period", 32'd10, n);
        wr_reg(`GTC_A_PSC, 32'h00000002);
        gap(n);
        chk("prescaled", 32'd30, n);
        wr_reg(`GTC_A_RCR, 32'h00000002);
        gap(n);
        chk("repeated", 32'd90, n);
        rd_chk("uif", `GTC_A_STAT, 32'h00000001, 32'h00000001);
        wr_reg(`GTC_A_CTRL, 32'h00000000);
        wr_reg(`GTC_A_RCR, 32'h00000000);
        wr_reg(`GTC_A_PSC, 32'h00000000);
        wr_reg(`GTC_A_STAT, 32'h0000001f);
        rd_chk("cleared", `GTC_A_STAT, 32'h00000000, 32'h0000001f);
        $display("test periods done");
        // ch1 pwm1 at 4 of 10, ch2 active on match at 0, two dead cycles
        wr_reg(`GTC_A_CHCFG, 32'h0000020c);
        wr_reg(`GTC_A_CH1, 32'h00000004);
        wr_reg(`GTC_A_BDTR, 32'h00000402);
        wr_reg(`GTC_A_EVGEN, 32'h00000001);
        wr_reg(`GTC_A_CTRL, 32'h00000001);
        gap(n);
        chk("pwm period", 32'd10, n);
        high_count(10);
        // each leg loses dead+1 cycles at its rising change
        chk("ch1 high", 32'd1, hi1);
        chk("ch1n high", 32'd3, hi2);
        #1 chk("ch2 level", 32'd1, ch2_out);
        rd_chk("cmp flag", `GTC_A_STAT, 32'h00000002, 32'h00000002);
        $display("test pwm done");
        wr_reg(`GTC_A_IEN, 32'h00000010);
        wr_reg(`GTC_A_BDTR, 32'h00000502);
        u_pins.pulse(1, 8);
        high_count(10);
        chk("brk ch1", 32'd0, hi1);
        chk("brk ch1n", 32'd0, hi2);
        #1 chk("brk req", 32'd1, evt_req);
        rd_chk("moe off", `GTC_A_BDTR, 32'h00000000, 32'h00000400);
        rd_chk("brk flag", `GTC_A_STAT, 32'h00000010, 32'h00000010);
        $display("test break done");
        wr_reg(`GTC_A_CTRL, 32'h00000000);
        wr_reg(`GTC_A_STAT, 32'h0000001f);
        wr_reg(`GTC_A_CNT, 32'h00001234);
        wr_reg(`GTC_A_CHCFG, 32'h00000001);
        wr_reg(`GTC_A_IEN, 32'h00000002);
        u_pins.pulse(2, 8);
        rd_chk("capture", `GTC_A_CH1, 32'h00001234, 32'hffffffff);
        rd_chk("cap flag", `GTC_A_STAT, 32'h00000002, 32'h00000002);
        $display("test capture done");
        end_of_test();
    end
endmodule
